// ### ssg_pkg.sv
// Package for the supervisor and SRAM gate: timing constants and grouped signals.
// Assumes a 20 MHz system clock.
package ssg_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned RST_HOLD_MS = 250;
    localparam int unsigned WDT_SHORT_MS = 250;
    localparam int unsigned WDT_MID_MS = 500;
    localparam int unsigned WDT_LONG_MS = 1000;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam logic [1:0] WDT_OFF = 2'h0;
    localparam logic [1:0] WDT_250 = 2'h1;
    localparam logic [1:0] WDT_500 = 2'h2;
    localparam logic [1:0] WDT_1000 = 2'h3;

    typedef struct packed {
        logic chip_select_n;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
    } ssg_host_sel_t;

    typedef struct packed {
        logic sram_high_enable_out_n;
        logic sram_low_enable_out_n;
    } ssg_sram_ce_t;
endpackage

// ### ssg_tick.sv
// Divider that produces a one-cycle enable pulse every TICK_CYCLES clocks.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module ssg_tick import ssg_pkg::*; #(
    parameter int unsigned DIV = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST,
    // Tick output.
    output logic TICK
);
    logic [$clog2(DIV)-1:0] cnt_ff;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cnt_ff <= '0;
            TICK <= 1'b0;
        end else if (cnt_ff == ($clog2(DIV))'(DIV - 1)) begin
            cnt_ff <= '0;
            TICK <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            TICK <= 1'b0;
        end
    end
endmodule

// ### ssg_top.sv
// Supervisor: SRAM chip-enable gating, power-fail, pushbutton and watchdog reset.
// Assumes a power-good level from an analog comparator and pins from outside the clock domain.
`timescale 1ns/1ps

// What this block does
// - Low enable follows select and low byte; high enable follows select and high byte.
// - Both SRAM enables stay inactive unless supply is within tolerance.
// - Each byte enable passes independently, allowing word and byte access.
// - Reset asserts on supply fault or watchdog timeout.
// - Each strobe falling edge restarts the watchdog count.
// - Watchdog setting selects off, 250 ms, 500 ms or 1000 ms.
// - An external low on the reset pin held past the 10 ms debounce yields a 250 ms reset pulse.
// - Reset stays active 250 ms after supply returns to tolerance.
// - Pushbutton is debounced; its reset pulse is at least 250 ms.
// - Strobe falling edge services the watchdog; with the watchdog not off, no service forces reset.
module ssg_top import ssg_pkg::*; #(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST,
    // Supply monitor and configuration.
    input wire logic POWER_GOOD,
    input wire logic [1:0] WDT_SEL,
    // Host side.
    input wire ssg_host_sel_t HOST_SEL,
    input wire logic WATCHDOG_STROBE_N,
    // SRAM side.
    output ssg_sram_ce_t SRAM_CE,
    // Reset pin, open drain: oe low drives the pin low.
    input wire logic HOST_RESET_N_IN,
    output logic HOST_RESET_N_OUT,
    output logic HOST_RESET_N_OE_N
);
    logic tick;
    logic [1:0] pg_sync_ff;
    logic [1:0] stb_sync_ff;
    logic [1:0] pin_sync_ff;
    logic [2:0] sel_sync_ff [2];
    logic [1:0] wsel_sync_ff [2];
    logic pg_ok;
    logic stb_q_ff;
    logic stb_fall;
    logic [$clog2(DEBOUNCE_MS+1)-1:0] db_cnt_ff;
    logic button_ff;
    logic driving_ff;
    logic [9:0] hold_cnt_ff;
    logic [10:0] wdt_cnt_ff;
    logic [10:0] wdt_limit;
    logic wdt_expire;
    logic reset_act;
    logic reset_act_q_ff;
    ssg_sram_ce_t nxt_ce;

    ssg_tick #(.DIV(TICK_DIV)) u_tick (
        .MCLK(MCLK),
        .RST(RST),
        .TICK(tick)
    );

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pg_sync_ff <= 2'h0;
            stb_sync_ff <= 2'h3;
            pin_sync_ff <= 2'h3;
            sel_sync_ff[0] <= 3'h7;
            sel_sync_ff[1] <= 3'h7;
            wsel_sync_ff[0] <= WDT_OFF;
            wsel_sync_ff[1] <= WDT_OFF;
        end else begin
            pg_sync_ff <= {pg_sync_ff[0], POWER_GOOD};
            stb_sync_ff <= {stb_sync_ff[0], WATCHDOG_STROBE_N};
            pin_sync_ff <= {pin_sync_ff[0], HOST_RESET_N_IN};
            sel_sync_ff[0] <= HOST_SEL;
            sel_sync_ff[1] <= sel_sync_ff[0];
            wsel_sync_ff[0] <= WDT_SEL;
            wsel_sync_ff[1] <= wsel_sync_ff[0];
        end
    end
    assign pg_ok = pg_sync_ff[1];

    // SRAM enables, blocked while the supply is out of tolerance.
    always_comb begin
        nxt_ce.sram_low_enable_out_n = sel_sync_ff[1][2] | sel_sync_ff[1][0] | ~pg_ok;
        nxt_ce.sram_high_enable_out_n = sel_sync_ff[1][2] | sel_sync_ff[1][1] | ~pg_ok;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SRAM_CE <= 2'h3;
        end else begin
            SRAM_CE <= nxt_ce;
        end
    end

    // Strobe falling edge is the service event.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            stb_q_ff <= 1'b1;
        end else begin
            stb_q_ff <= stb_sync_ff[1];
        end
    end
    assign stb_fall = stb_q_ff & ~stb_sync_ff[1];

    // Pushbutton debounce; the pin is ignored while this block drives it.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            db_cnt_ff <= '0;
            button_ff <= 1'b0;
        end else if (driving_ff || pin_sync_ff[1]) begin
            db_cnt_ff <= '0;
            button_ff <= 1'b0;
        end else if (tick) begin
            if (db_cnt_ff == ($bits(db_cnt_ff))'(DEBOUNCE_MS)) begin
                button_ff <= 1'b1;
            end else begin
                db_cnt_ff <= db_cnt_ff + 1'b1;
            end
        end
    end

    // Watchdog limit from the setting.
    always_comb begin
        case (wsel_sync_ff[1])
            WDT_250: wdt_limit = 11'(WDT_SHORT_MS);
            WDT_500: wdt_limit = 11'(WDT_MID_MS);
            WDT_1000: wdt_limit = 11'(WDT_LONG_MS);
            default: wdt_limit = 11'h0;
        endcase
    end

    assign wdt_expire = (wsel_sync_ff[1] != WDT_OFF) && (wdt_cnt_ff >= wdt_limit);

    // Watchdog count in millisecond ticks; cleared by service and during reset.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wdt_cnt_ff <= 11'h0;
        end else if (reset_act || stb_fall || wsel_sync_ff[1] == WDT_OFF) begin
            wdt_cnt_ff <= 11'h0;
        end else if (tick && !wdt_expire) begin
            wdt_cnt_ff <= wdt_cnt_ff + 11'h1;
        end
    end

    // Reset drive with a 250 ms hold after every cause clears.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            driving_ff <= 1'b1;
            hold_cnt_ff <= 10'h0;
        end else if (!pg_ok || wdt_expire || button_ff) begin
            driving_ff <= 1'b1;
            hold_cnt_ff <= 10'h0;
        end else if (driving_ff && tick) begin
            if (hold_cnt_ff == 10'(RST_HOLD_MS - 1)) begin
                driving_ff <= 1'b0;
            end else begin
                hold_cnt_ff <= hold_cnt_ff + 10'h1;
            end
        end
    end
    assign reset_act = driving_ff;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            reset_act_q_ff <= 1'b1;
        end else begin
            reset_act_q_ff <= reset_act;
        end
    end

    assign HOST_RESET_N_OUT = 1'b0;
    assign HOST_RESET_N_OE_N = ~driving_ff;

    sram_gate_a: assert property (@(posedge MCLK) disable iff (RST)
        !pg_ok |=> (SRAM_CE == 2'h3)) else $error("SRAM enabled while supply bad");
    low_follow_a: assert property (@(posedge MCLK) disable iff (RST)
        (pg_ok && !sel_sync_ff[1][2] && !sel_sync_ff[1][0]) |=> !SRAM_CE.sram_low_enable_out_n)
        else $error("Low enable not passed");
    high_follow_a: assert property (@(posedge MCLK) disable iff (RST)
        (pg_ok && !sel_sync_ff[1][2] && !sel_sync_ff[1][1]) |=> !SRAM_CE.sram_high_enable_out_n)
        else $error("High enable not passed");
    fault_reset_a: assert property (@(posedge MCLK) disable iff (RST)
        (!pg_ok || wdt_expire) |=> !HOST_RESET_N_OE_N) else $error("Reset missing on fault");
    service_clear_a: assert property (@(posedge MCLK) disable iff (RST)
        stb_fall |=> wdt_cnt_ff == 11'h0) else $error("Strobe did not restart watchdog");
    wdt_period_a: assert property (@(posedge MCLK) disable iff (RST)
        wdt_expire |-> ((wsel_sync_ff[1] == WDT_250 && wdt_cnt_ff >= 11'(WDT_SHORT_MS))
        || (wsel_sync_ff[1] == WDT_500 && wdt_cnt_ff >= 11'(WDT_MID_MS))
        || (wsel_sync_ff[1] == WDT_1000 && wdt_cnt_ff >= 11'(WDT_LONG_MS))))
        else $error("Watchdog expired off period");
    hold_length_a: assert property (@(posedge MCLK) disable iff (RST)
        $fell(driving_ff) |-> hold_cnt_ff == 10'(RST_HOLD_MS - 1))
        else $error("Reset hold too short");
    button_reset_a: assert property (@(posedge MCLK) disable iff (RST)
        button_ff |=> driving_ff && hold_cnt_ff == 10'h0) else $error("Button reset lost");
    wdt_restart_a: assert property (@(posedge MCLK) disable iff (RST)
        $fell(reset_act_q_ff) |-> wdt_cnt_ff == 11'h0) else $error("Watchdog not restarted");
endmodule

// ### ssg_host_model.sv
// Host model: watchdog strobe source and the open-drain reset pin with a pushbutton.
// Assumes the device pulls the pin low while its enable is low; a pull-up holds it high.
`timescale 1ns/1ps
module ssg_host_model #(
    parameter int unsigned PERIOD = 1000
) (
    input wire logic mclk,
    input wire logic strobe_en,
    input wire logic button,
    input wire logic drv_out,
    input wire logic drv_oe_n,
    output logic strobe_n,
    output logic pin_n
);
    int unsigned cnt = 0;
    initial strobe_n = 1'b1;
    // Strobe toggles well inside the timeout while enabled and idles high.
    always @(posedge mclk) begin
        cnt <= (!strobe_en || cnt == PERIOD - 1) ? 0 : cnt + 1;
        if (!strobe_en) strobe_n <= #5 1'b1;
        else if (cnt == PERIOD - 1) strobe_n <= #5 ~strobe_n;
    end
    // Pin is a wired AND of the device drive, the button and the pull-up.
    assign pin_n = (drv_oe_n ? 1'b1 : drv_out) & ~button;
endmodule

// ### tb_top.sv
// Self-checking bench for the supervisor and SRAM gate.
// Assumes a shortened tick so each millisecond lasts TD clocks.
`timescale 1ns/1ps
module tb_top import ssg_pkg::*;;
    localparam int TD = 10;
    localparam int HOLD = RST_HOLD_MS * TD;
    typedef struct packed {ssg_host_sel_t sel; ssg_sram_ce_t ce;} ssg_row_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic power_good = 1'b1;
    logic [1:0] wdt_sel = WDT_OFF;
    ssg_host_sel_t host_sel = 3'h7;
    logic strobe_en = 1'b0;
    logic button = 1'b0;
    logic strobe_n, pin_n, drv_out, drv_oe_n;
    ssg_sram_ce_t sram_ce;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    int lims [3] = '{WDT_SHORT_MS, WDT_MID_MS, WDT_LONG_MS};
    ssg_row_t rows [5] = '{{3'h0, 2'h0}, {3'h2, 2'h2}, {3'h1, 2'h1}, {3'h3, 2'h3}, {3'h4, 2'h3}};
    ssg_top #(.TICK_DIV(TD)) DUT (.MCLK(mclk), .RST(rst), .POWER_GOOD(power_good),
        .WDT_SEL(wdt_sel), .HOST_SEL(host_sel), .WATCHDOG_STROBE_N(strobe_n),
        .SRAM_CE(sram_ce), .HOST_RESET_N_IN(pin_n), .HOST_RESET_N_OUT(drv_out),
        .HOST_RESET_N_OE_N(drv_oe_n));
    ssg_host_model #(.PERIOD(100 * TD)) host (.mclk(mclk), .strobe_en(strobe_en),
        .button(button), .drv_out(drv_out), .drv_oe_n(drv_oe_n), .strobe_n(strobe_n),
        .pin_n(pin_n));
    initial forever #25 mclk = ~mclk;
    task automatic wrap_up;
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic fail(string msg);
        err_count++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask
    task automatic chk_ce(ssg_sram_ce_t exp);
        num_checks++;
        if (sram_ce !== exp) fail("sram enables");
    endtask
    task automatic chk_oe(logic exp);
        num_checks++;
        if (drv_oe_n !== exp || drv_out !== 1'b0) fail("reset drive");
    endtask
    task automatic chk_span(int got, int lo, int hi);
        num_checks++;
        if (got < lo || got > hi) fail("duration");
    endtask
    task automatic step(int k);
        repeat (k) @(posedge mclk);
        #5;
    endtask
    // Counts clocks until the reset drive reaches a level, up to a bound.
    task automatic wait_oe(logic lvl, int max, output int cnt);
        cnt = 0;
        while (drv_oe_n !== lvl && cnt < max) begin
            step(1);
            cnt++;
        end
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            fail("timeout");
            wrap_up;
        end
    end
    initial begin
        step(10);
        rst = 1'b0;
        wait_oe(1'b1, HOLD + 4 * TD, n);
        chk_span(n, HOLD - TD, HOLD + 3 * TD);
        foreach (rows[i]) begin
            host_sel = rows[i].sel;
            step(5);
            chk_ce(rows[i].ce);
        end
        host_sel = 3'h0;
        wait_oe(1'b0, 1100 * TD, n);
        chk_oe(1'b1);
        power_good = 1'b0;
        step(6);
        chk_ce(2'h3);
        chk_oe(1'b0);
        for (int m = 1; m < 4; m++) begin
            wdt_sel = m[1:0];
            power_good = 1'b1;
            wait_oe(1'b1, HOLD + 4 * TD, n);
            chk_span(n, HOLD - TD, HOLD + 3 * TD);
            wait_oe(1'b0, lims[m-1] * TD + 4 * TD, n);
            chk_span(n, lims[m-1] * TD - TD, lims[m-1] * TD + 3 * TD);
        end
        wdt_sel = WDT_250;
        strobe_en = 1'b1;
        wait_oe(1'b1, HOLD + 4 * TD, n);
        wait_oe(1'b0, 1000 * TD, n);
        chk_oe(1'b1);
        wdt_sel = WDT_OFF;
        strobe_en = 1'b0;
        button = 1'b1;
        step(3 * TD);
        button = 1'b0;
        wait_oe(1'b0, 20 * TD, n);
        chk_oe(1'b1);
        button = 1'b1;
        wait_oe(1'b0, 15 * TD, n);
        chk_oe(1'b0);
        step(20 * TD);
        button = 1'b0;
        wait_oe(1'b1, HOLD + 40 * TD, n);
        chk_span(n + 20 * TD, HOLD - TD, HOLD + 35 * TD);
        rst = 1'b1;
        step(2);
        chk_ce(2'h3);
        chk_oe(1'b0);
        rst = 1'b0;
        wait_oe(1'b1, HOLD + 4 * TD, n);
        chk_span(n, HOLD - TD, HOLD + 3 * TD);
        chk_ce(2'h0);
        wrap_up;
    end
endmodule
